/* hdl/sppc_top.sv */
// Serial peripheral port: registers, master/slave shift engine, pin control.
// Assumes pins arrive asynchronously; pad logic resolves oe/out pairs.
`timescale 1ns/1ps
`default_nettype none
module sppc_top
  import sppc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  // Break state
  input  wire logic       break_in,
  input  wire logic       break_clear_enable_in,
  // Pins
  input  wire logic       miso_in,
  output var  logic       miso_out,
  output var  logic       miso_oe_out,
  input  wire logic       mosi_in,
  output var  logic       mosi_out,
  output var  logic       mosi_oe_out,
  input  wire logic       sck_in,
  output var  logic       sck_out,
  output var  logic       sck_oe_out,
  input  wire logic       ss_n_in,
  output var  logic       ss_owned_out,
  output var  logic       wired_or_out,
  // Interrupt requests
  output var  logic       rx_irq_out,
  output var  logic       tx_irq_out
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  miso_s;    // Pin synchronisers
    logic [2:0]  mosi_s;
    logic [2:0]  sck_s;
    logic [2:0]  ss_s;
    logic        sck_f;     // Filtered pin levels
    logic        ss_f;
    logic [7:0]  ctrl;      // serial_control
    logic [3:0]  sctl;      // error_irq_enable, fden, rate
    logic        rxf;
    logic        ovr;
    logic        mode_fault_flag;
    logic        txe;
    logic        rx_arm;    // First step of two-step clears
    logic        mode_fault_flag_arm;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic [7:0]  div;
    sppc_state_t st;
    logic        busy;
    logic        m_first;   // Master: first clock edge still to come
    logic        sck_o;
    logic        bitout;
    logic [7:0]  rdata;
  } sppc_s_t;
  sppc_s_t q, d;
  logic [1:0] rst_sync_q;         // Reset release pipe, own process
  logic rst_n;                    // Released reset copy
  logic [7:0] half;               // Half period for master clock
  logic en, mstr, clock_polarity, clock_phase, slv_sel, ss_rise, ss_fall, sck_edge;
  logic lead_edge, trail_edge, done, wr_data, rd_stat, rd_data;
  logic can_clr;                  // Flag clearing allowed now
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    en   = q.ctrl[SPPC_C_EN];
    mstr = q.ctrl[SPPC_C_MSTR];
    clock_polarity = q.ctrl[SPPC_C_CLOCK_POLARITY];
    clock_phase = q.ctrl[SPPC_C_CLOCK_PHASE];
    can_clr = !break_in || break_clear_enable_in;
    // Three-stage pin pipes; level accepted when last two agree
    d.miso_s = {q.miso_s[1:0], miso_in};
    d.mosi_s = {q.mosi_s[1:0], mosi_in};
    d.sck_s  = {q.sck_s[1:0], sck_in};
    d.ss_s   = {q.ss_s[1:0], ss_n_in};
    if (q.sck_s[2] == q.sck_s[1])
      d.sck_f = q.sck_s[1];
    if (q.ss_s[2] == q.ss_s[1])
      d.ss_f = q.ss_s[1];
    ss_rise  = !q.ss_f && d.ss_f;
    ss_fall  = q.ss_f && !d.ss_f;
    sck_edge = q.sck_f != d.sck_f;
    slv_sel  = en && !mstr && !q.ss_f;
    case (q.sctl[1:0])
      2'b00:   half = SPPC_HALF_0;
      2'b01:   half = SPPC_HALF_1;
      2'b10:   half = SPPC_HALF_2;
      default: half = SPPC_HALF_3;
    endcase
    // Register strobes
    wr_data = wr_in && addr_in == SPPC_ADDR_DATA && can_clr;
    rd_stat = rd_in && addr_in == SPPC_ADDR_STAT;
    rd_data = rd_in && addr_in == SPPC_ADDR_DATA;
    // Read mux; unmapped reads zero
    if (rd_in && addr_in == SPPC_ADDR_CTRL)
      d.rdata = q.ctrl;
    else if (rd_stat)
      d.rdata = {q.rxf, q.sctl[3], q.ovr, q.mode_fault_flag, q.txe, q.sctl[2], q.sctl[1:0]};
    else if (rd_data)
      d.rdata = q.rxbuf;
    else
      d.rdata = 8'h00;
    // Control writes
    if (wr_in && addr_in == SPPC_ADDR_CTRL)
      d.ctrl = wdata_in;
    if (wr_in && addr_in == SPPC_ADDR_STAT)
      d.sctl = {wdata_in[SPPC_S_ERROR_IRQ_ENABLE], wdata_in[SPPC_S_FDEN], wdata_in[1:0]};
    // Two-step clears; arming held through break
    if (rd_stat && q.rxf && can_clr)
      d.rx_arm = 1'b1;
    if (rd_stat && q.mode_fault_flag && can_clr)
      d.mode_fault_flag_arm = 1'b1;
    if (rd_data && can_clr)
    begin
      d.rxf = 1'b0;
      if (q.rx_arm)
        d.ovr = 1'b0;
      d.rx_arm = 1'b0;
    end
    if (wr_data && q.mode_fault_flag_arm)
    begin
      d.mode_fault_flag = 1'b0;
      d.mode_fault_flag_arm = 1'b0;
    end
    // Data write queues into transmit buffer
    if (wr_data)
    begin
      d.txbuf = wdata_in;
      d.txe = 1'b0;
    end
    lead_edge = 1'b0;
    trail_edge = 1'b0;
    done = 1'b0;
    if (!en)
    begin
      // Partial reset while disabled
      d.st = SPPC_IDLE;
      d.busy = 1'b0;
      d.shreg = 8'h00;
      d.bitcnt = 4'h0;
      d.div = 8'h00;
      d.sck_o = clock_polarity;
      d.txe = 1'b1;
    end
    else if (mstr)
    begin
      case (q.st)
        SPPC_IDLE:
        begin
          d.sck_o = clock_polarity;
          if (!q.txe && !wr_data)
          begin
            d.shreg = q.txbuf;
            d.txe = 1'b1;
            d.busy = 1'b1;
            d.bitcnt = 4'h0;
            d.div = 8'h00;
            d.bitout = q.txbuf[7];
            d.m_first = 1'b1;
            d.st = SPPC_LEAD;
          end
        end
        SPPC_LEAD:
        begin
          d.div = q.div + 8'h01;
          if (q.div + 8'h01 == half)
          begin
            d.div = 8'h00;
            d.m_first = 1'b0;
            d.st = SPPC_TRAIL;
            // Phase one: last bit taken one half after the final edge
            if (clock_phase && q.bitcnt == SPPC_BITS - 4'h1)
              lead_edge = 1'b1;
            else
            begin
              d.sck_o = !q.sck_o;
              // Miso pipe lags three clocks, so sample one half late
              if (clock_phase && !q.m_first)
              begin
                lead_edge = 1'b1;
                trail_edge = 1'b1;
              end
            end
          end
        end
        SPPC_TRAIL:
        begin
          d.div = q.div + 8'h01;
          if (q.div + 8'h01 == half)
          begin
            d.div = 8'h00;
            d.sck_o = !q.sck_o;
            d.st = SPPC_LEAD;
            // Phase zero samples late, on the return-to-idle edge
            if (!clock_phase)
            begin
              lead_edge = 1'b1;
              trail_edge = 1'b1;
            end
          end
        end
        default: d.st = SPPC_IDLE;
      endcase
    end
    else
    begin
      // Slave engine; deselect freezes state
      d.sck_o = clock_polarity;
      if (!q.busy && !q.txe && !wr_data)
      begin
        d.shreg = q.txbuf;
        d.txe = 1'b1;
      end
      if (!clock_phase && ss_fall && !q.busy)
      begin
        d.busy = 1'b1;
        d.bitcnt = 4'h0;
        d.bitout = d.shreg[7];
      end
      if (slv_sel && sck_edge)
      begin
        if ((d.sck_f != clock_polarity) != clock_phase)
          lead_edge = 1'b1;
        else
          trail_edge = 1'b1;
        if (clock_phase && !q.busy && d.sck_f != clock_polarity)
        begin
          d.busy = 1'b1;
          d.bitcnt = 4'h0;
          d.bitout = d.shreg[7]; // First edge shifts out the top bit
        end
      end
    end
    // Shared shift: sample on leading, shift out on trailing
    if (lead_edge && q.busy)
    begin
      d.shreg = {q.shreg[6:0], mstr ? q.miso_s[2] : q.mosi_s[2]};
      d.bitcnt = q.bitcnt + 4'h1;
      if (q.bitcnt + 4'h1 == SPPC_BITS)
        done = 1'b1;
    end
    // After a same-cycle shift the outgoing bit is the fresh top bit
    if (trail_edge && q.busy)
      d.bitout = d.shreg[7];
    if (done)
    begin
      d.busy = 1'b0;
      d.st = SPPC_IDLE;
      d.sck_o = clock_polarity;
      // A data read in this same cycle frees the register: set wins
      if (d.rxf)
        d.ovr = 1'b1; // Last byte lost
      else
      begin
        d.rxbuf = d.shreg;
        d.rxf = 1'b1;
      end
    end
    // Mode fault detection
    if (en && q.sctl[2])
    begin
      if (!mstr && q.busy && ss_rise)
        d.mode_fault_flag = 1'b1;
      if (mstr && ss_fall)
      begin
        d.mode_fault_flag = 1'b1;
        d.ctrl[SPPC_C_EN] = 1'b0; // Master disabled by fault
      end
    end
  end
  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.miso_s <= 3'h0;
      q.mosi_s <= 3'h0;
      q.sck_s <= 3'h0;
      q.ss_s <= 3'h7;
      q.sck_f <= 1'b0;
      q.ss_f <= 1'b1;
      q.ctrl <= SPPC_CTRL_RST;
      q.sctl <= SPPC_STAT_CTL_RST;
      q.rxf <= 1'b0;
      q.ovr <= 1'b0;
      q.mode_fault_flag <= 1'b0;
      q.txe <= 1'b1;
      q.rx_arm <= 1'b0;
      q.mode_fault_flag_arm <= 1'b0;
      q.txbuf <= 8'h00;
      q.rxbuf <= 8'h00;
      q.shreg <= 8'h00;
      q.bitcnt <= 4'h0;
      q.div <= 8'h00;
      q.st <= SPPC_IDLE;
      q.busy <= 1'b0;
      q.m_first <= 1'b0;
      q.sck_o <= 1'b0;
      q.bitout <= 1'b0;
      q.rdata <= 8'h00;
    end
    else if (ce_in)
    begin
      q.miso_s <= d.miso_s;
      q.mosi_s <= d.mosi_s;
      q.sck_s <= d.sck_s;
      q.ss_s <= d.ss_s;
      q.sck_f <= d.sck_f;
      q.ss_f <= d.ss_f;
      q.ctrl <= d.ctrl;
      q.sctl <= d.sctl;
      q.rxf <= d.rxf;
      q.ovr <= d.ovr;
      q.mode_fault_flag <= d.mode_fault_flag;
      q.txe <= d.txe;
      q.rx_arm <= d.rx_arm;
      q.mode_fault_flag_arm <= d.mode_fault_flag_arm;
      q.txbuf <= d.txbuf;
      q.rxbuf <= d.rxbuf;
      q.shreg <= d.shreg;
      q.bitcnt <= d.bitcnt;
      q.div <= d.div;
      q.st <= d.st;
      q.busy <= d.busy;
      q.m_first <= d.m_first;
      q.sck_o <= d.sck_o;
      q.bitout <= d.bitout;
      q.rdata <= d.rdata;
    end
  end
  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_out <= 8'h00;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
      ss_owned_out <= 1'b0;
      wired_or_out <= 1'b0;
      rx_irq_out <= 1'b0;
      tx_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rdata_out <= d.rdata;
      // Open drain: only drive low when wired-or set
      miso_out <= d.bitout;
      miso_oe_out <= d.ctrl[SPPC_C_EN] && !d.ctrl[SPPC_C_MSTR] && !d.ss_f
                     && (!d.ctrl[SPPC_C_WOM] || !d.bitout);
      mosi_out <= d.bitout;
      mosi_oe_out <= d.ctrl[SPPC_C_EN] && d.ctrl[SPPC_C_MSTR]
                     && (!d.ctrl[SPPC_C_WOM] || !d.bitout);
      sck_out <= d.sck_o;
      sck_oe_out <= d.ctrl[SPPC_C_EN] && d.ctrl[SPPC_C_MSTR]
                    && (!d.ctrl[SPPC_C_WOM] || !d.sck_o);
      // Select owned unless disabled or plain master
      ss_owned_out <= d.ctrl[SPPC_C_EN] && (!d.ctrl[SPPC_C_MSTR] || d.sctl[2]);
      wired_or_out <= d.ctrl[SPPC_C_WOM];
      rx_irq_out <= d.ctrl[SPPC_C_EN] && d.ctrl[SPPC_C_RXIE] && d.rxf;
      tx_irq_out <= d.ctrl[SPPC_C_TXIE] && d.txe;
    end
  end
endmodule // sppc_top
`default_nettype wire

/* shared/sppc_pkg.sv */
// Constants for the serial peripheral port block.
// Assumes a single 50 MHz bus clock and an 8-bit register port.
package sppc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPPC_ADDR_CTRL   = 8'h10; // serial_control
  localparam logic [7:0] SPPC_ADDR_STAT   = 8'h11; // serial_status_control
  localparam logic [7:0] SPPC_ADDR_DATA   = 8'h12; // serial_data
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SPPC_C_RXIE   = 7;
  localparam int SPPC_C_MSTR   = 5;
  localparam int SPPC_C_CLOCK_POLARITY   = 4;
  localparam int SPPC_C_CLOCK_PHASE   = 3;
  localparam int SPPC_C_WOM    = 2;
  localparam int SPPC_C_EN     = 1;
  localparam int SPPC_C_TXIE   = 0;
  localparam logic [7:0] SPPC_CTRL_RST = 8'h28; // Master and phase set
  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int SPPC_S_RXF    = 7;
  localparam int SPPC_S_ERROR_IRQ_ENABLE  = 6;
  localparam int SPPC_S_OVR    = 5;
  localparam int SPPC_S_MODE_FAULT_FLAG   = 4;
  localparam int SPPC_S_TXE    = 3;
  localparam int SPPC_S_FDEN   = 2;
  localparam logic [3:0] SPPC_STAT_CTL_RST = 4'h0; // error_irq_enable,fden,rate
  // ----------------------------------------------------------------
  // Rate divisor half periods, in module clocks (divisor 4,16,64,256)
  // ----------------------------------------------------------------
  localparam logic [7:0] SPPC_HALF_0 = 8'h02;
  localparam logic [7:0] SPPC_HALF_1 = 8'h08;
  localparam logic [7:0] SPPC_HALF_2 = 8'h20;
  localparam logic [7:0] SPPC_HALF_3 = 8'h80;
  localparam logic [3:0] SPPC_BITS   = 4'h8;
  // ----------------------------------------------------------------
  // Shift engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPPC_IDLE = 3'b001,
    SPPC_LEAD = 3'b010,
    SPPC_TRAIL = 3'b100
  } sppc_state_t;
endpackage

/* test/sppc_chk.sv */
// Checker for the serial port: pin ownership and control side effects.
// Assumes one clock, active-low reset; attached to the top by bind.
`timescale 1ns/1ps
`default_nettype none
module sppc_chk
  import sppc_pkg::*;
(
  // Clock, reset, register port
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  // Pins and flags
  input wire logic       ss_n_in,
  input wire logic       miso_oe_out,
  input wire logic       mosi_oe_out,
  input wire logic       sck_oe_out,
  input wire logic       sck_out,
  input wire logic       ss_owned_out,
  input wire logic       wired_or_out,
  input wire logic       rx_irq_out
);
  // ------------------------------------------------------------
  // Control write strobe
  // ------------------------------------------------------------
  wire cw = wr_in && addr_in == SPPC_ADDR_CTRL; // Control write
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Six cycles cover the pin synchroniser delay
  miso_float_a: assert property (ss_n_in [*6] |-> !miso_oe_out)
    else $error("miso driven while deselected");
  slave_drive_a: assert property (miso_oe_out |-> !sck_oe_out && !mosi_oe_out)
    else $error("miso driven by a master");
  // Open drain lets the two enables part, so only push-pull is tied
  pin_dir_a: assert property (!wired_or_out |-> mosi_oe_out == sck_oe_out)
    else $error("mosi and sck directions differ");
  wired_or_a: assert property (cw |-> ##2 wired_or_out == $past(wdata_in[2], 2))
    else $error("wired-or output wrong");
  slave_ss_a: assert property (cw && wdata_in[1] && !wdata_in[5] |-> ##2 ss_owned_out)
    else $error("slave select not owned");
  off_pins_a: assert property (cw && !wdata_in[1]
    |-> ##2 !(ss_owned_out || sck_oe_out || mosi_oe_out || miso_oe_out))
    else $error("disabled port holds pins");
  rx_gate_a: assert property (cw && !wdata_in[7] |-> ##2 !rx_irq_out)
    else $error("receive request not gated");
  sck_idle_a: assert property (cw && wdata_in[1] && wdata_in[5] && !wdata_in[2]
    |-> ##3 sck_oe_out && sck_out == $past(wdata_in[4], 3))
    else $error("serial clock idle level wrong");
endmodule // sppc_chk
`default_nettype wire

/* test/sppc_peer.sv */
// External master model: select, clock and MOSI out, MISO sampled.
// Assumes polarity zero on both ends; phase given by the bench.
`timescale 1ns/1ps
`default_nettype none
module sppc_peer #(parameter int H = 10)
(
  // Bench control
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       clock_phase_in,
  input  wire logic [7:0] tx_in,
  input  wire logic       miso_in,
  // Pins and result
  output var  logic       ss_n_out,
  output var  logic       sck_out,
  output var  logic       mosi_out,
  output var  logic       busy_out,
  output var  logic [7:0] rx_out
);
  // One byte per select pulse; select rises after every byte
  initial
  begin
    ss_n_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
    busy_out = 1'b0;
    rx_out = 8'h00;
    forever
    begin
      @(posedge clk_in);
      // Idle line toggles, so stale data never looks valid
      if (!go_in) mosi_out <= ~mosi_out;
      else
      begin
        busy_out <= 1'b1;
        ss_n_out <= 1'b0;
        mosi_out <= tx_in[7];
        for (int i = 7; i >= 0; i--)
        begin
          repeat (H) @(posedge clk_in);
          sck_out <= 1'b1;
          if (clock_phase_in) mosi_out <= tx_in[i];
          else rx_out[i] <= miso_in;
          repeat (H) @(posedge clk_in);
          sck_out <= 1'b0;
          if (clock_phase_in) rx_out[i] <= miso_in;
          else if (i > 0) mosi_out <= tx_in[i-1];
        end
        repeat (H) @(posedge clk_in);
        ss_n_out <= 1'b1;
        busy_out <= 1'b0;
      end
    end
  end
endmodule // sppc_peer
`default_nettype wire

/* test/test_sppc_top.sv */
// Bench for the serial port: register tasks, loopback master, slave driven by the peer.
// Assumes a 50 MHz clock and the peer model as the external master.
`timescale 1ns/1ps
`default_nettype none
module test_sppc_top;
  import sppc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and wires
  // ------------------------------------------------------------
  logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, break_in = 0;
  logic break_clear_enable_in = 0, loop = 0, ss_pull = 0, pat = 0;
  logic go = 0, cph = 1;
  logic [7:0] addr_in = 0, wdata_in = 0, ptx = 0, s;
  wire logic [7:0] rdata_out, prx;
  wire logic miso_out, miso_oe_out, mosi_out, mosi_oe_out, sck_out, sck_oe_out;
  wire logic ss_owned_out, wired_or_out, rx_irq_out, tx_irq_out, pss, psck, pmosi, pbusy;
  int n_errors = 0, checks = 0;
  // Wire levels worked out from every driver
  wire logic sck_in = sck_oe_out ? sck_out : psck;
  wire logic mosi_in = mosi_oe_out ? mosi_out : pmosi;
  wire logic miso_in = loop ? mosi_out : (miso_oe_out ? miso_out : pat);
  wire logic ss_n_in = pss & ~ss_pull;
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) pat <= ~pat; // Floating line pattern
  sppc_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .break_in(break_in), .break_clear_enable_in(break_clear_enable_in),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .ss_n_in(ss_n_in),
    .ss_owned_out(ss_owned_out), .wired_or_out(wired_or_out), .rx_irq_out(rx_irq_out),
    .tx_irq_out(tx_irq_out));
  sppc_peer peer_u (.clk_in(clk_in), .go_in(go), .clock_phase_in(cph), .tx_in(ptx),
    .miso_in(miso_in), .ss_n_out(pss), .sck_out(psck), .mosi_out(pmosi),
    .busy_out(pbusy), .rx_out(prx));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Poll status until receive-full, bounded
  task wait_rx(output logic [7:0] v);
    v = 0;
    for (int n = 0; n < 2000 && v[7] !== 1'b1; n++) rd(SPPC_ADDR_STAT, v);
  endtask
  // Half period of the serial clock, in module clocks
  task half(output logic [7:0] c);
    logic b;
    b = sck_out;
    c = 0;
    while (sck_out === b && c < 250)
    begin
      tick;
      c++;
    end
  endtask
  // One peer frame, optionally writing data mid-frame
  task frame(input logic [7:0] t, input logic mid);
    ptx <= t;
    go <= 1'b1;
    tick;
    go <= 1'b0;
    if (mid)
    begin
      repeat (60) tick;
      wr(SPPC_ADDR_DATA, 8'h99);
    end
    for (int n = 0; n < 600 && pbusy === 1'b1; n++) tick;
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_errors++;
    wrap_up;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] c;
    logic [7:0] bd [4];
    bd = '{8'h02, 8'h08, 8'h20, 8'h80};
    repeat (20) tick;
    rstn_in <= 1'b1;
    repeat (4) tick;
    rd(SPPC_ADDR_CTRL, s);
    chk8(s, 8'h28);
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h08);
    rd(8'h20, s);
    chk8(s, 8'h00);
    // Master loopback at every rate
    loop <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      wr(SPPC_ADDR_STAT, 8'(r));
      wr(SPPC_ADDR_CTRL, 8'h22);
      repeat (4) tick;
      chk8({7'h0, ss_owned_out}, 8'h00);
      wr(SPPC_ADDR_DATA, 8'h5a ^ 8'(r));
      half(c);
      half(c);
      chk8(c, bd[r]);
      wait_rx(s);
      chk8(s, 8'h88 | 8'(r));
      wr(SPPC_ADDR_CTRL, 8'ha2);
      repeat (3) tick;
      chk8({7'h0, rx_irq_out}, 8'h01);
      rd(SPPC_ADDR_DATA, s);
      chk8(s, 8'h5a ^ 8'(r));
      repeat (3) tick;
      chk8({7'h0, rx_irq_out}, 8'h00);
    end
    // Idle clock level follows polarity one
    wr(SPPC_ADDR_CTRL, 8'h32);
    repeat (4) tick;
    chk8({7'h0, sck_out}, 8'h01);
    // Break protects the data register
    wr(SPPC_ADDR_STAT, 8'h00);
    wr(SPPC_ADDR_CTRL, 8'h22);
    break_in <= 1'b1;
    wr(SPPC_ADDR_DATA, 8'h77);
    repeat (80) tick;
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h08);
    break_in <= 1'b0;
    wr(SPPC_ADDR_DATA, 8'h11);
    wait_rx(s);
    break_in <= 1'b1;
    break_clear_enable_in <= 1'b1;
    rd(SPPC_ADDR_DATA, s);
    chk8(s, 8'h11);
    break_in <= 1'b0;
    break_clear_enable_in <= 1'b0;
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h08);
    // Status read before break arms the clear; break holds the flag
    wr(SPPC_ADDR_DATA, 8'h44);
    wait_rx(s);
    break_in <= 1'b1;
    rd(SPPC_ADDR_DATA, s);
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h88);
    break_in <= 1'b0;
    rd(SPPC_ADDR_DATA, s);
    chk8(s, 8'h44);
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h08);
    wr(SPPC_ADDR_CTRL, 8'h27);
    repeat (3) tick;
    chk8({7'h0, wired_or_out}, 8'h01);
    chk8({7'h0, tx_irq_out}, 8'h01);
    // Slave, phase one, with a write during the frame
    loop <= 1'b0;
    wr(SPPC_ADDR_CTRL, 8'h0a);
    repeat (4) tick;
    chk8({7'h0, ss_owned_out}, 8'h01);
    wr(SPPC_ADDR_DATA, 8'h3c);
    frame(8'hc3, 1'b1);
    chk8(prx, 8'h3c);
    rd(SPPC_ADDR_DATA, s);
    chk8(s, 8'hc3);
    frame(8'h5a, 1'b0);
    chk8(prx, 8'h99);
    rd(SPPC_ADDR_DATA, s);
    chk8(s, 8'h5a);
    // Slave, phase zero
    cph <= 1'b0;
    wr(SPPC_ADDR_CTRL, 8'h02);
    wr(SPPC_ADDR_DATA, 8'ha6);
    frame(8'h6a, 1'b0);
    chk8(prx, 8'ha6);
    rd(SPPC_ADDR_DATA, s);
    chk8(s, 8'h6a);
    // Fault-watching master sees select pulled low
    wr(SPPC_ADDR_STAT, 8'h04);
    wr(SPPC_ADDR_CTRL, 8'h22);
    repeat (4) tick;
    chk8({7'h0, ss_owned_out}, 8'h01);
    ss_pull <= 1'b1;
    repeat (10) tick;
    ss_pull <= 1'b0;
    rd(SPPC_ADDR_STAT, s);
    chk8(s, 8'h1c);
    rd(SPPC_ADDR_CTRL, s);
    chk8(s, 8'h20);
    wrap_up;
  end
endmodule // test_sppc_top
bind sppc_top sppc_chk chk_u (.*);
`default_nettype wire
